// >>> inc/ckss_defs.svh
// Purpose: Offsets, field positions, reset values and counts for ckss
// Assumes: Included by bare name, definitions only
// Notes:   Counts are in cycles of the named oscillator
`ifndef CKSS_DEFS_SVH
`define CKSS_DEFS_SVH

// Register byte offsets
`define CKSS_OFS_CTRL     12'h000
`define CKSS_OFS_SLEEP    12'h004
`define CKSS_OFS_STATUS   12'h008

// Field positions
`define CKSS_CTRL_MODE_LSB  0
`define CKSS_SLEEP_GO_BIT   0
`define CKSS_STAT_CLOCK_SOURCE_SELECT_LSB 0
`define CKSS_STAT_SUT_LSB   4
`define CKSS_STAT_DIV8_BIT  6
`define CKSS_STAT_INVAL_BIT 7
`define CKSS_STAT_STATE_LSB 8

// Reset values, factory default fuse settings (0 = programmed)
`define CKSS_CLOCK_SOURCE_SELECT_DFLT   4'h2
`define CKSS_SUT_DFLT     2'h2
`define CKSS_DIV8_DFLT    1'h0
`define CKSS_MODE_DFLT    3'h0

// Source-select codes
`define CKSS_CLOCK_SOURCE_SELECT_RESV   4'h1

// Supply time-out, watchdog oscillator cycles
`define CKSS_TOUT_SHORT   512
`define CKSS_TOUT_LONG    8192

// Oscillator stabilisation, selected oscillator cycles
`define CKSS_STAB_EXT     6
`define CKSS_STAB_258     258
`define CKSS_STAB_1K      1024
`define CKSS_STAB_16K     16384
`define CKSS_STAB_32K     32768
`define CKSS_RST_DELAY    14
`define CKSS_DIV_FACTOR   8

// Bus response codes
`define CKSS_RESP_OKAY    2'h0
`define CKSS_RESP_SLVERR  2'h2

`endif

// >>> inc/ckss_pkg.sv
// Purpose: Types shared by the clock select and start-up sequencer
// Assumes: Constants live in ckss_defs.svh
// Notes:   Binary state codes written out
package ckss_pkg;

	typedef enum logic [2:0] {
		ST_HOLD    = 3'h0,
		ST_TOUT    = 3'h1,
		ST_STAB    = 3'h2,
		ST_RUN     = 3'h3,
		ST_SLEEP   = 3'h4,
		ST_WAKE    = 3'h5,
		ST_INVALID = 3'h6
	} ckss_state_t;

	typedef enum logic [2:0] {
		SRC_LP_XTAL = 3'h0,
		SRC_FS_XTAL = 3'h1,
		SRC_LF_XTAL = 3'h2,
		SRC_RC_128K = 3'h3,
		SRC_RC_CAL  = 3'h4,
		SRC_EXT     = 3'h5
	} ckss_src_t;

	typedef enum logic [2:0] {
		SLP_IDLE     = 3'h0,
		SLP_ADC_NR   = 3'h1,
		SLP_PWR_DOWN = 3'h2,
		SLP_PWR_SAVE = 3'h3,
		SLP_STANDBY  = 3'h6,
		SLP_EXT_STBY = 3'h7
	} ckss_sleep_t;

endpackage : ckss_pkg

// >>> core/ckss_sync.sv
// Purpose: Two-stage synchroniser for pin-level inputs
// Assumes: Inputs are quasi-static or slow against aclk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module ckss_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	initial begin
		if (WIDTH < 1) begin
			$error("ckss_sync: WIDTH must be at least 1");
		end
	end

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end

endmodule : ckss_sync

// >>> core/ckss_seq.sv
// Purpose: Clock source select, start-up sequencing and domain gating
// Assumes: Oscillators and fuses arrive as pins, sampled on aclk
// Notes:   Clock domains leave as enables; registers over AXI4-Lite
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ckss_defs.svh"
module ckss_seq #(
	parameter int CNT_W      = 16,
	parameter int TOUT_LONG  = `CKSS_TOUT_LONG,
	parameter int STAB_16K   = `CKSS_STAB_16K,
	parameter int STAB_32K   = `CKSS_STAB_32K
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Configuration fuses, 0 = programmed
	input  wire logic [3:0]  clock_source_select,
	input  wire logic [1:0]  startup_time_select,
	input  wire logic        divide_by_eight_option,
	// Reset sources, oscillators, wake pins
	input  wire logic        other_reset_active,
	input  wire logic        watchdog_osc,
	input  wire logic [5:0]  osc_in,
	input  wire logic        wake_event,
	input  wire logic        wake_level,
	// Clock domain enables and status
	output logic             internal_reset,
	output logic             system_tick,
	output logic             core_clock_en,
	output logic             program_memory_clock_en,
	output logic             peripheral_clock_en,
	output logic             async_detect_en,
	output logic             async_timer_clock_en,
	output logic             converter_clock_en,
	output logic             level_wake_irq,
	output logic             config_invalid
);

	localparam int SW = 17;

	initial begin
		if (CNT_W < 16 || TOUT_LONG < 1 || STAB_16K < 1 ||
		    STAB_32K < 1 || STAB_32K >= (1 << CNT_W) ||
		    TOUT_LONG >= (1 << CNT_W) ||
		    STAB_16K + `CKSS_RST_DELAY >= (1 << CNT_W)) begin
			$error("ckss_seq: counter too narrow or bad count");
		end
	end

	// Pin synchronisation
	logic [SW-1:0] pin_s;
	ckss_sync #(.WIDTH(SW)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({clock_source_select, startup_time_select,
		            divide_by_eight_option, other_reset_active,
		            watchdog_osc, osc_in, wake_event, wake_level}),
		.sync_out (pin_s)
	);
	logic [3:0] clock_source_select_s;
	logic [1:0] sut_s;
	logic       div8_s;
	logic       rst_src_s;
	logic       wdt_s;
	logic [5:0] osc_s;
	logic       wake_ev_s;
	logic       wake_lvl_s;
	assign {clock_source_select_s, sut_s, div8_s, rst_src_s, wdt_s, osc_s,
	        wake_ev_s, wake_lvl_s} = pin_s;

	// Source decode
	function automatic ckss_pkg::ckss_src_t src_of(input logic [3:0] c);
		if (c[3])
			return ckss_pkg::SRC_LP_XTAL;
		else if (c[3:1] == 3'h3)
			return ckss_pkg::SRC_FS_XTAL;
		else if (c[3:1] == 3'h2)
			return ckss_pkg::SRC_LF_XTAL;
		else if (c == 4'h3)
			return ckss_pkg::SRC_RC_128K;
		else if (c == 4'h2)
			return ckss_pkg::SRC_RC_CAL;
		else
			return ckss_pkg::SRC_EXT;
	endfunction : src_of

	function automatic logic is_xtal(input logic [3:0] c);
		return c[3] || c[3:1] == 3'h3;
	endfunction : is_xtal

	// Supply time-out in watchdog cycles
	function automatic logic [CNT_W-1:0] tout_of(input logic [3:0] c,
	                                            input logic [1:0] s);
		logic [2:0] k;
		k = {c[0], s};
		if (!is_xtal(c))
			k = {1'b1, s[1] ? 2'h3 : (s[0] ? 2'h2 : 2'h1)};
		case (k)
			3'h0, 3'h3, 3'h6: return CNT_W'(`CKSS_TOUT_SHORT);
			3'h2, 3'h5:       return '0;
			default:          return CNT_W'(TOUT_LONG);
		endcase
	endfunction : tout_of

	// Stabilisation count in oscillator cycles
	function automatic logic [CNT_W-1:0] stab_of(input logic [3:0] c,
	                                            input logic [1:0] s);
		if (is_xtal(c)) begin
			case ({c[0], s})
				3'h0, 3'h1: return CNT_W'(`CKSS_STAB_258 + `CKSS_RST_DELAY);
				3'h2, 3'h3, 3'h4:
				            return CNT_W'(`CKSS_STAB_1K + `CKSS_RST_DELAY);
				default:    return CNT_W'(STAB_16K + `CKSS_RST_DELAY);
			endcase
		end else if (c[3:1] == 3'h2) begin
			return CNT_W'(STAB_32K);
		end else begin
			return CNT_W'(`CKSS_STAB_EXT);
		end
	endfunction : stab_of

	// Register decode
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		case (a)
			`CKSS_OFS_CTRL:   return 2'h1;
			`CKSS_OFS_SLEEP:  return 2'h2;
			`CKSS_OFS_STATUS: return 2'h3;
			default:          return 2'h0;
		endcase
	endfunction : reg_sel

	// Bus slave state
	logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic        wstrb0_r, wstrb0_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt;
	logic        arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic [2:0]  mode_r, mode_nxt;
	logic        sleep_go_r, sleep_go_nxt;

	// Sequencer state
	ckss_pkg::ckss_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [3:0]  clock_source_select_r, clock_source_select_nxt;
	logic [1:0]  sut_r, sut_nxt;
	logic        div8_r, div8_nxt;
	logic        osc_prev_r, osc_prev_nxt, wdt_prev_r, wdt_prev_nxt;
	logic [2:0]  div_r, div_nxt;
	logic        lvl_wake_r, lvl_wake_nxt;
	logic        osc_sel, osc_edge, wdt_edge, wake_any;
	logic        tick_nxt, irq_nxt, inval_nxt, irst_nxt;
	logic        core_nxt, io_nxt, asy_nxt, adc_nxt;

	// Bus slave
	always_comb begin
		aw_have_nxt  = aw_have_r;
		w_have_nxt   = w_have_r;
		awaddr_nxt   = awaddr_r;
		wdata_nxt    = wdata_r;
		wstrb0_nxt   = wstrb0_r;
		bvalid_nxt   = s_axi_bvalid && !s_axi_bready;
		bresp_nxt    = s_axi_bresp;
		rvalid_nxt   = s_axi_rvalid && !s_axi_rready;
		rresp_nxt    = s_axi_rresp;
		rdata_nxt    = s_axi_rdata;
		mode_nxt     = mode_r;
		sleep_go_nxt = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb0_nxt = s_axi_wstrb[0];
		end
		if (aw_have_r && w_have_r && !s_axi_bvalid) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = `CKSS_RESP_OKAY;
			case (reg_sel(awaddr_r))
				2'h1: if (wstrb0_r) begin
					mode_nxt = wdata_r[`CKSS_CTRL_MODE_LSB +: 3];
				end
				2'h2: sleep_go_nxt = wstrb0_r &&
				                     wdata_r[`CKSS_SLEEP_GO_BIT];
				2'h3: ;
				default: bresp_nxt = `CKSS_RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = `CKSS_RESP_OKAY;
			rdata_nxt  = '0;
			case (reg_sel(s_axi_araddr))
				2'h1: rdata_nxt[`CKSS_CTRL_MODE_LSB +: 3] = mode_r;
				2'h2: ;
				2'h3: begin
					rdata_nxt[`CKSS_STAT_CLOCK_SOURCE_SELECT_LSB +: 4] = clock_source_select_r;
					rdata_nxt[`CKSS_STAT_SUT_LSB +: 2]   = sut_r;
					rdata_nxt[`CKSS_STAT_DIV8_BIT]       = div8_r;
					rdata_nxt[`CKSS_STAT_INVAL_BIT]      = config_invalid;
					rdata_nxt[`CKSS_STAT_STATE_LSB +: 3] = state_r;
				end
				default: rresp_nxt = `CKSS_RESP_SLVERR;
			endcase
		end
		awready_nxt = !aw_have_nxt;
		wready_nxt  = !w_have_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= '0;
			wstrb0_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CKSS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `CKSS_RESP_OKAY;
			s_axi_rdata   <= '0;
			mode_r        <= `CKSS_MODE_DFLT;
			sleep_go_r    <= 1'b0;
		end else begin
			aw_have_r     <= aw_have_nxt;
			w_have_r      <= w_have_nxt;
			awaddr_r      <= awaddr_nxt;
			wdata_r       <= wdata_nxt;
			wstrb0_r      <= wstrb0_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rdata   <= rdata_nxt;
			mode_r        <= mode_nxt;
			sleep_go_r    <= sleep_go_nxt;
		end
	end

	// Start-up sequencer and sleep control
	always_comb begin
		osc_sel      = osc_s[src_of(clock_source_select_r)];
		osc_edge     = osc_sel && !osc_prev_r;
		wdt_edge     = wdt_s && !wdt_prev_r;
		wake_any     = wake_ev_s || wake_lvl_s;
		osc_prev_nxt = osc_sel;
		wdt_prev_nxt = wdt_s;
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		clock_source_select_nxt    = clock_source_select_r;
		sut_nxt      = sut_r;
		div8_nxt     = div8_r;
		div_nxt      = div_r;
		lvl_wake_nxt = lvl_wake_r;
		irq_nxt      = 1'b0;
		tick_nxt     = 1'b0;
		case (state_r)
			ckss_pkg::ST_HOLD: begin
				clock_source_select_nxt = clock_source_select_s;
				sut_nxt   = sut_s;
				div8_nxt  = div8_s;
				cnt_nxt   = tout_of(clock_source_select_s, sut_s);
				if (!rst_src_s) begin
					state_nxt = ckss_pkg::ST_TOUT;
				end
			end
			ckss_pkg::ST_TOUT: begin
				if (clock_source_select_r == `CKSS_CLOCK_SOURCE_SELECT_RESV) begin
					state_nxt = ckss_pkg::ST_INVALID;
				end else if (cnt_r == '0) begin
					state_nxt = ckss_pkg::ST_STAB;
					cnt_nxt   = stab_of(clock_source_select_r, sut_r);
				end else if (wdt_edge) begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			ckss_pkg::ST_STAB, ckss_pkg::ST_WAKE: begin
				if (cnt_r == '0) begin
					state_nxt = ckss_pkg::ST_RUN;
					irq_nxt   = lvl_wake_r && wake_lvl_s;
					lvl_wake_nxt = 1'b0;
				end else if (osc_edge) begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			ckss_pkg::ST_RUN: begin
				if (sleep_go_r) begin
					state_nxt = ckss_pkg::ST_SLEEP;
				end
			end
			ckss_pkg::ST_SLEEP: begin
				if (wake_any) begin
					lvl_wake_nxt = wake_lvl_s;
					if (mode_r == ckss_pkg::SLP_PWR_DOWN ||
					    mode_r == ckss_pkg::SLP_PWR_SAVE) begin
						state_nxt = ckss_pkg::ST_WAKE;
						cnt_nxt   = stab_of(clock_source_select_r, sut_r);
					end else begin
						state_nxt = ckss_pkg::ST_RUN;
						irq_nxt   = wake_lvl_s;
						lvl_wake_nxt = 1'b0;
					end
				end
			end
			ckss_pkg::ST_INVALID: ;
			default: state_nxt = ckss_pkg::ST_HOLD;
		endcase
		if (rst_src_s) begin
			state_nxt = ckss_pkg::ST_HOLD;
		end
		if (osc_edge) begin
			div_nxt  = div_r + 3'h1;
			tick_nxt = div8_r || div_r == 3'(`CKSS_DIV_FACTOR - 1);
		end
	end

	// Domain gating per state and sleep mode
	always_comb begin
		irst_nxt  = 1'b0;
		inval_nxt = state_nxt == ckss_pkg::ST_INVALID;
		core_nxt  = 1'b0;
		io_nxt    = 1'b0;
		asy_nxt   = 1'b0;
		adc_nxt   = 1'b0;
		case (state_nxt)
			ckss_pkg::ST_RUN: begin
				core_nxt = 1'b1;
				io_nxt   = 1'b1;
				asy_nxt  = 1'b1;
				adc_nxt  = 1'b1;
			end
			ckss_pkg::ST_SLEEP, ckss_pkg::ST_WAKE: begin
				case (mode_r)
					ckss_pkg::SLP_IDLE: begin
						io_nxt  = 1'b1;
						asy_nxt = 1'b1;
						adc_nxt = 1'b1;
					end
					ckss_pkg::SLP_ADC_NR: begin
						asy_nxt = 1'b1;
						adc_nxt = 1'b1;
					end
					ckss_pkg::SLP_PWR_SAVE, ckss_pkg::SLP_EXT_STBY:
						asy_nxt = 1'b1;
					default: asy_nxt = 1'b0;
				endcase
			end
			default: irst_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r        <= ckss_pkg::ST_HOLD;
			cnt_r          <= '0;
			clock_source_select_r        <= `CKSS_CLOCK_SOURCE_SELECT_DFLT;
			sut_r          <= `CKSS_SUT_DFLT;
			div8_r         <= `CKSS_DIV8_DFLT;
			osc_prev_r     <= 1'b0;
			wdt_prev_r     <= 1'b0;
			div_r          <= '0;
			lvl_wake_r     <= 1'b0;
			internal_reset <= 1'b1;
			system_tick    <= 1'b0;
			core_clock_en  <= 1'b0;
			program_memory_clock_en <= 1'b0;
			peripheral_clock_en     <= 1'b0;
			async_detect_en         <= 1'b0;
			async_timer_clock_en    <= 1'b0;
			converter_clock_en      <= 1'b0;
			level_wake_irq <= 1'b0;
			config_invalid <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			cnt_r          <= cnt_nxt;
			clock_source_select_r        <= clock_source_select_nxt;
			sut_r          <= sut_nxt;
			div8_r         <= div8_nxt;
			osc_prev_r     <= osc_prev_nxt;
			wdt_prev_r     <= wdt_prev_nxt;
			div_r          <= div_nxt;
			lvl_wake_r     <= lvl_wake_nxt;
			internal_reset <= irst_nxt;
			system_tick    <= tick_nxt;
			core_clock_en  <= core_nxt;
			program_memory_clock_en <= core_nxt;
			peripheral_clock_en     <= io_nxt;
			async_detect_en         <= !irst_nxt;
			async_timer_clock_en    <= asy_nxt;
			converter_clock_en      <= adc_nxt;
			level_wake_irq <= irq_nxt;
			config_invalid <= inval_nxt;
		end
	end

endmodule : ckss_seq

// >>> dv/ckss_props.sv
// Purpose: Port-level assertions for ckss_seq
// Assumes: Bound to every ckss_seq instance, one clock domain
// Notes:   Reset on aresetn disables every check
`timescale 1ns/1ps
module ckss_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Reset source
	input wire logic other_reset_active,
	// Watched outputs
	input wire logic internal_reset,
	input wire logic system_tick,
	input wire logic core_clock_en,
	input wire logic program_memory_clock_en,
	input wire logic peripheral_clock_en,
	input wire logic async_detect_en,
	input wire logic async_timer_clock_en,
	input wire logic converter_clock_en,
	input wire logic level_wake_irq,
	input wire logic config_invalid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_INVALID_HOLDS: assert property (config_invalid |-> internal_reset)
		else $error("config_invalid without internal reset");
	AST_FLASH_FOLLOWS: assert property (
		program_memory_clock_en == core_clock_en)
		else $error("program memory clock differs from core clock");
	AST_CORE_OFF_RST: assert property (internal_reset |-> !core_clock_en)
		else $error("core clock on during internal reset");
	AST_RUN_ALL_ON: assert property (core_clock_en |->
		peripheral_clock_en && async_timer_clock_en && converter_clock_en)
		else $error("domain off while core clock runs");
	AST_ADC_WITH_IO: assert property (peripheral_clock_en |-> converter_clock_en)
		else $error("converter clock off while peripheral clock on");
	AST_ASY_WITH_ADC: assert property (
		converter_clock_en |-> async_timer_clock_en)
		else $error("async timer clock off while converter clock on");
	AST_DETECT_ALIVE: assert property (!internal_reset |-> async_detect_en)
		else $error("async detect off outside reset");
	AST_TICK_PULSE: assert property (system_tick |=> !system_tick)
		else $error("system tick longer than one cycle");
	AST_IRQ_PULSE: assert property (level_wake_irq |->
		!internal_reset ##1 !level_wake_irq [*8])
		else $error("wake interrupt malformed");
	AST_RELEASE_SRC: assert property (
		$fell(internal_reset) |-> !$past(other_reset_active, 2))
		else $error("reset released while another source active");
endmodule : ckss_props

bind ckss_seq ckss_props u_props (.aclk, .aresetn, .other_reset_active,
	.internal_reset, .system_tick, .core_clock_en, .program_memory_clock_en,
	.peripheral_clock_en, .async_detect_en, .async_timer_clock_en,
	.converter_clock_en, .level_wake_irq, .config_invalid);

// >>> dv/ckss_osc_model.sv
// Purpose: Free-running watchdog and source oscillators
// Assumes: Periods are whole aclk multiples, phase offset by 1 ns
// Notes:   Source i period is 10+2i aclk cycles, watchdog 9
`timescale 1ns/1ps
module ckss_osc_model (
	// Oscillator outputs
	output logic       watchdog_osc,
	output logic [5:0] osc_in
);
	initial begin
		watchdog_osc = 1'b0;
		#1;
		forever #18 watchdog_osc = ~watchdog_osc;
	end
	for (genvar i = 0; i < 6; i++) begin : g_osc
		initial begin
			osc_in[i] = 1'b0;
			#1;
			forever #(20 + 4 * i) osc_in[i] = ~osc_in[i];
		end
	end
endmodule : ckss_osc_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for ckss_seq
// Assumes: Shortened long counts, oscillators from ckss_osc_model
// Notes:   Bus results checked by a monitor from expectation queues
`timescale 1ns/1ps
`include "ckss_defs.svh"
module testbench;
	localparam int TL = 16, S16 = 20, S32 = 24, PW = 9, CEIL = 90000;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, clock_source_select = 4'h2;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, divide_by_eight_option = 1'b0;
	logic        other_reset_active = 1'b1, wake_event = 1'b0;
	logic        wake_level = 1'b0, watchdog_osc;
	logic [1:0]  startup_time_select = 2'h2, s_axi_bresp, s_axi_rresp;
	logic [5:0]  osc_in;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, internal_reset, system_tick, core_clock_en;
	logic        program_memory_clock_en, peripheral_clock_en;
	logic        async_detect_en, async_timer_clock_en, converter_clock_en;
	logic        level_wake_irq, config_invalid;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          n_errors = 0, compares = 0, cyc = 0, irq_cnt = 0;

	always #2 aclk = ~aclk;
	ckss_osc_model u_osc (.watchdog_osc(watchdog_osc), .osc_in(osc_in));
	ckss_seq #(.TOUT_LONG(TL), .STAB_16K(S16), .STAB_32K(S32)) u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .clock_source_select,
		.startup_time_select, .divide_by_eight_option, .other_reset_active,
		.watchdog_osc, .osc_in, .wake_event, .wake_level, .internal_reset,
		.system_tick, .core_clock_en, .program_memory_clock_en,
		.peripheral_clock_en, .async_detect_en, .async_timer_clock_en,
		.converter_clock_en, .level_wake_irq, .config_invalid);

	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		compares++;
		if (got !== ex) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic rng(string nm, int lo, int hi, int got);
		compares++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : rng

	task automatic axw(logic [11:0] a, logic [31:0] d, logic [3:0] s,
		logic [1:0] er);
		bq.push_back(er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
		rq.push_back({er, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic boot(logic [3:0] cs, logic [1:0] su, logic d8, int tout,
		int stab, int po);
		int n;
		@(posedge aclk);
		other_reset_active <= 1'b1;
		clock_source_select <= cs;
		startup_time_select <= su;
		divide_by_eight_option <= d8;
		repeat (8) @(posedge aclk);
		other_reset_active <= 1'b0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (internal_reset !== 1'b0);
		rng("startup cycles", tout * PW + stab * po - PW - po,
			tout * PW + stab * po + PW + po + 10, n);
		axr(`CKSS_OFS_STATUS, {21'h0, 3'h3, 1'b0, d8, su, cs}, 2'h0);
		while (system_tick !== 1'b1) @(posedge aclk);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (system_tick !== 1'b1);
		chk("tick period", d8 ? po : 8 * po, n);
		$display("Test boot %h done", cs);
	endtask : boot

	task automatic wake(bit lvl, int hold, int lo, int hi, int irqs);
		int n;
		int c0;
		c0 = irq_cnt;
		n = 0;
		@(posedge aclk);
		if (lvl) wake_level <= 1'b1;
		else wake_event <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (n == hold) wake_level <= 1'b0;
		end while (core_clock_en !== 1'b1);
		if (n < hold) wake_level <= 1'b0;
		wake_event <= 1'b0;
		repeat (3) @(posedge aclk);
		rng("wake cycles", lo, hi, n);
		chk("wake irq count", irqs, irq_cnt - c0);
	endtask : wake

	always @(posedge aclk) begin
		logic [33:0] e;
		cyc++;
		if (level_wake_irq === 1'b1) irq_cnt++;
		if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			chk("rdata", e[31:0], s_axi_rdata);
			chk("rresp", e[33:32], s_axi_rresp);
		end
		if (cyc == CEIL) begin
			n_errors++;
			$display("Error timeout expected done seen running");
			give_verdict();
		end
	end

	initial begin
		int md[6] = '{0, 1, 2, 3, 6, 7};
		logic [2:0] ge[6] = '{3'h7, 3'h3, 3'h0, 3'h2, 3'h0, 3'h2};
		void'($urandom(32'hBD20FB9E));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		boot(4'h0, 2'h0, 1'b1, 0, 6, 20);
		boot(4'h3, 2'h1, 1'b0, 512, 6, 16);
		boot(4'hF, 2'h3, 1'b1, TL, S16 + 14, 10);
		boot(4'h8, 2'h0, 1'b0, 512, 272, 10);
		boot(4'h4, 2'h2, 1'b1, TL, S32, 14);
		boot(4'h6, 2'h2, 1'b0, 0, 1038, 12);
		other_reset_active <= 1'b1;
		clock_source_select <= 4'h1;
		divide_by_eight_option <= 1'b0;
		repeat (8) @(posedge aclk);
		other_reset_active <= 1'b0;
		repeat (40) @(posedge aclk);
		chk("config_invalid", 1, config_invalid);
		chk("internal_reset", 1, internal_reset);
		axr(`CKSS_OFS_STATUS, {21'h0, 3'h6, 1'b1, 1'b0, 2'h2, 4'h1}, 2'h0);
		$display("Test invalid source done");
		boot(4'h2, 2'h2, 1'b0, TL, 6, 18);
		for (int i = 0; i < 6; i++) begin
			axw(`CKSS_OFS_CTRL, ($urandom() & 32'hFFFFFF00) | md[i], 4'hF, 2'h0);
			axr(`CKSS_OFS_CTRL, md[i], 2'h0);
			axw(`CKSS_OFS_SLEEP, 32'h1, 4'hF, 2'h0);
			repeat (6) @(posedge aclk);
			chk("gating", {1'b0, ge[i]}, {core_clock_en, peripheral_clock_en,
				async_timer_clock_en, converter_clock_en});
			if (md[i] == 2 || md[i] == 3) wake(1'b1, 1000, 85, 138, 1);
			else wake(1'b0, 1000, 1, 12, 0);
		end
		axw(`CKSS_OFS_CTRL, 32'h2, 4'hF, 2'h0);
		axw(`CKSS_OFS_SLEEP, 32'h1, 4'hF, 2'h0);
		repeat (6) @(posedge aclk);
		wake(1'b1, 3 + $urandom_range(3), 85, 138, 0);
		$display("Test sleep and wake done");
		axr(12'h00C, 32'h0, `CKSS_RESP_SLVERR);
		axw(12'h010, 32'h3, 4'hF, `CKSS_RESP_SLVERR);
		axw(`CKSS_OFS_STATUS, 32'hFF, 4'hF, `CKSS_RESP_OKAY);
		axw(`CKSS_OFS_CTRL, 32'h5, 4'hE, `CKSS_RESP_OKAY);
		axr(`CKSS_OFS_CTRL, 32'h2, `CKSS_RESP_OKAY);
		axr(`CKSS_OFS_SLEEP, 32'h0, `CKSS_RESP_OKAY);
		axr(`CKSS_OFS_STATUS, {21'h0, 3'h3, 1'b0, 1'b0, 2'h2, 4'h2}, 2'h0);
		$display("Test bus refusals done");
		repeat (4) @(posedge aclk);
		give_verdict();
	end
endmodule : testbench
